/* src/rosl_top.sv */
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rosl_defines.svh"

module rosl_top
    import rosl_pkg::*;
#(
    parameter int          IN_SELS = 34,
    parameter bit          HAS_CAN = 1'b1
) (
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_n,
    input  wire logic [`ROSL_ADDR_W-1:0]       i_addr,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    input  wire logic [31:0]                   i_device_config_word_three,
    input  wire rosl_periph_t                  i_periph,
    output logic      [31:0]                   o_rdata,
    output logic      [`ROSL_NUM_OUT-1:0]      o_pin_out,
    output logic      [`ROSL_NUM_OUT-1:0]      o_pin_en,
    output logic      [IN_SELS-1:0][3:0]       o_in_sel,
    output logic                               o_mapping_lock
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (IN_SELS < 1 || IN_SELS > 64) begin : g_bad_in_sels
        $error("IN_SELS must lie in 1..64");
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [1:0] grp_of(input int idx);
        grp_of = (idx < `ROSL_GRP2_START) ? 2'h0 :
                 (idx < `ROSL_GRP3_START) ? 2'h1 :
                 (idx < `ROSL_GRP4_START) ? 2'h2 : 2'h3;
    endfunction

    // returns {enable, level}; reserved codes fall to the default
    function automatic logic [1:0] pin_mux(input logic [1:0] grp, input logic [3:0] code,
                                           input rosl_periph_t p);
        pin_mux = 2'h0;
        unique case (grp)
            2'h0: begin
                case (code)
                    4'h1: pin_mux = {1'b1, p.uart3_transmit};
                    4'h2: pin_mux = {1'b1, p.uart4_request_to_send};
                    4'h6: pin_mux = {1'b1, p.spi2_data_out};
                    4'hb: pin_mux = {1'b1, p.compare_output_3};
                    4'hc: pin_mux = HAS_CAN ? {1'b1, p.can1_transmit} : 2'h0;
                    4'hd: pin_mux = {1'b1, p.comparator2_output};
                    4'he: pin_mux = {1'b1, p.spi3_data_out};
                    4'hf: pin_mux = {1'b1, p.spi4_data_out};
                    default: pin_mux = 2'h0;
                endcase
            end
            2'h1: begin
                case (code)
                    4'h1: pin_mux = {1'b1, p.uart2_transmit};
                    4'h3: pin_mux = {1'b1, p.uart1_transmit};
                    4'h4: pin_mux = {1'b1, p.uart5_request_to_send};
                    4'h8: pin_mux = {1'b1, p.spi1_data_out};
                    4'hb: pin_mux = {1'b1, p.compare_output_4};
                    4'he: pin_mux = {1'b1, p.spi3_data_out};
                    4'hf: pin_mux = {1'b1, p.spi4_data_out};
                    default: pin_mux = 2'h0;
                endcase
            end
            2'h2: begin
                case (code)
                    4'h1: pin_mux = {1'b1, p.uart3_request_to_send};
                    4'h2: pin_mux = {1'b1, p.uart4_transmit};
                    4'h3: pin_mux = {1'b1, p.reference_clock_out};
                    4'h4: pin_mux = {1'b1, p.uart5_transmit};
                    4'h7: pin_mux = {1'b1, p.spi1_select};
                    4'h8: pin_mux = {1'b1, p.spi1_data_out};
                    4'hb: pin_mux = {1'b1, p.compare_output_5};
                    4'hd: pin_mux = {1'b1, p.comparator1_output};
                    4'he: pin_mux = {1'b1, p.spi3_select};
                    4'hf: pin_mux = {1'b1, p.spi4_select};
                    default: pin_mux = 2'h0;
                endcase
            end
            2'h3: begin
                case (code)
                    4'h1: pin_mux = {1'b1, p.uart2_request_to_send};
                    4'h3: pin_mux = {1'b1, p.uart1_request_to_send};
                    4'h4: pin_mux = {1'b1, p.uart5_transmit};
                    4'h6: pin_mux = {1'b1, p.spi2_select};
                    4'h8: pin_mux = {1'b1, p.spi1_data_out};
                    4'hb: pin_mux = {1'b1, p.compare_output_2};
                    4'hc: pin_mux = {1'b1, p.compare_output_1};
                    default: pin_mux = 2'h0;
                endcase
            end
        endcase
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [3:0]           out_sel [`ROSL_NUM_OUT];
    logic                 mapping_lock;
    logic                 one_way_lock_option;
    logic                 cfg_captured;
    logic [31:0]          dcfg_word;
    rosl_key_t            key_state;
    rosl_key_t            next_key_state;
    logic                 next_lock;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire       cfg_hit  = (i_addr == `ROSL_CFG_ADDR);
    wire       key_hit  = (i_addr == `ROSL_KEY_ADDR);
    wire       dcfg_hit = (i_addr == `ROSL_DCFG_ADDR);
    wire [5:0] sel_idx  = i_addr[7:2];
    wire       aligned  = (i_addr[1:0] == 2'h0);
    wire       out_hit  = aligned && (i_addr[11:8] == `ROSL_OUT_REGION)
                          && (int'(sel_idx) < `ROSL_NUM_OUT);
    wire       in_hit   = aligned && (i_addr[11:8] == `ROSL_IN_REGION)
                          && (int'(sel_idx) < IN_SELS);
    wire       sel_wr_ok = i_wr && !mapping_lock;

    // ----------------------------------------
    // unlock sequence
    // ----------------------------------------
    // any write to the config register closes the window again, so each
    // lock change needs a fresh pair of keys
    assign next_key_state = (i_wr && key_hit && i_wdata == `ROSL_KEY_FIRST) ? KEY_HALF :
                            (i_wr && key_hit && i_wdata == `ROSL_KEY_SECOND && key_state == KEY_HALF)
                                ? KEY_OPEN :
                            (i_wr && (key_hit || cfg_hit)) ? KEY_IDLE : key_state;

    // ----------------------------------------
    // lock bit
    // ----------------------------------------
    // key needed
    wire lock_wr   = i_wr && cfg_hit && (key_state == KEY_OPEN);
    wire clr_block = one_way_lock_option && mapping_lock;
    assign next_lock = !lock_wr ? mapping_lock :
                       i_wdata[`ROSL_LOCK_BIT] ? 1'b1 :
                       clr_block ? mapping_lock : 1'b0;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mapping_lock <= `ROSL_LOCK_RST;
            key_state    <= KEY_IDLE;
        end else begin
            mapping_lock <= next_lock;
            key_state    <= next_key_state;
        end
    end

    // ----------------------------------------
    // config word capture
    // ----------------------------------------
    // the option is held set until the word is sampled, the safe direction
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_captured        <= 1'b0;
            one_way_lock_option <= 1'b1;
            dcfg_word           <= 32'hffff_ffff;
        end else if (!cfg_captured) begin
            cfg_captured        <= 1'b1;
            one_way_lock_option <= i_device_config_word_three[`ROSL_ONEWAY_BIT];
            dcfg_word           <= i_device_config_word_three;
        end
    end

    // ----------------------------------------
    // selectors
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < `ROSL_NUM_OUT; i++) begin
                out_sel[i] <= `ROSL_SEL_RST;
            end
        end else if (sel_wr_ok && out_hit) begin
            out_sel[sel_idx] <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_in_sel <= '0;
        end else if (sel_wr_ok && in_hit) begin
            o_in_sel[sel_idx] <= i_wdata[3:0];
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // reads ignore the lock
    wire [31:0] rd_word = cfg_hit  ? (32'h0 | (32'(mapping_lock) << `ROSL_LOCK_BIT)) :
                          key_hit  ? {30'h0, key_state} :
                          dcfg_hit ? dcfg_word :
                          out_hit  ? {28'h0, out_sel[sel_idx]} :
                          in_hit   ? {28'h0, o_in_sel[sel_idx]} : 32'h0;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata        <= 32'h0;
            o_mapping_lock <= `ROSL_LOCK_RST;
        end else begin
            o_rdata        <= i_rd ? rd_word : 32'h0;
            o_mapping_lock <= next_lock;
        end
    end

    // ----------------------------------------
    // pin output stage
    // ----------------------------------------
    // registered so the pins never see a mux glitch; costs one cycle of latency
    logic [`ROSL_NUM_OUT-1:0] pin_lvl;
    logic [`ROSL_NUM_OUT-1:0] pin_drv;

    for (genvar g = 0; g < `ROSL_NUM_OUT; g++) begin : g_pin
        assign {pin_drv[g], pin_lvl[g]} = pin_mux(grp_of(g), out_sel[g], i_periph);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_out <= '0;
            o_pin_en  <= '0;
        end else begin
            o_pin_out <= pin_lvl & pin_drv;
            o_pin_en  <= pin_drv;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    wire wr_out0 = i_wr && out_hit && (sel_idx == 6'h0);

    a_locked_write_kept: assert property (
        wr_out0 && mapping_lock |=> $stable(out_sel[0]))
        else $error("selector changed while locked");

    a_lock_readback: assert property (
        i_rd && cfg_hit |=> o_rdata[`ROSL_LOCK_BIT] == $past(mapping_lock) && o_rdata[12:0] == 13'h0)
        else $error("lock bit not at its position");

    a_lock_needs_key: assert property (
        mapping_lock != $past(mapping_lock) |-> $past(key_state) == KEY_OPEN && $past(i_wr && cfg_hit))
        else $error("lock changed without unlock");

    a_oneway_hold: assert property (
        mapping_lock && one_way_lock_option |=> mapping_lock)
        else $error("one-way lock was cleared");

    a_oneway_default: assert property (
        !cfg_captured |-> one_way_lock_option)
        else $error("option not set before capture");

    a_nc_code_idle: assert property (
        out_sel[0] == 4'h0 |=> !o_pin_en[0])
        else $error("pin driven with code zero");

    a_pin_follows_sel: assert property (
        out_sel[0] == 4'h1 |=> o_pin_en[0] && o_pin_out[0] == $past(i_periph.uart3_transmit))
        else $error("pin not following its selection");

    a_reserved_quiet: assert property (
        out_sel[0] == 4'h3 || out_sel[0] == 4'h9 |=> !o_pin_en[0])
        else $error("reserved code drives pin");

    a_can_absent: assert property (
        out_sel[0] == 4'hc |=> o_pin_en[0] == HAS_CAN
                               && o_pin_out[0] == (HAS_CAN && $past(i_periph.can1_transmit)))
        else $error("can selection does not match the build");

    a_insel_write: assert property (
        i_wr && in_hit && sel_idx == 6'h0 && !mapping_lock |=> o_in_sel[0] == $past(i_wdata[3:0]))
        else $error("input selector write lost");

    a_read_free: assert property (
        i_rd && out_hit && sel_idx == 6'h0 |=> o_rdata == {28'h0, $past(out_sel[0])})
        else $error("selector read wrong");

    // one pin per group is watched; the bench walks every code on exactly those pins
    a_grp2_route: assert property (
        out_sel[`ROSL_GRP2_START] == 4'h3
            |=> o_pin_en[`ROSL_GRP2_START] && o_pin_out[`ROSL_GRP2_START] == $past(i_periph.uart1_transmit))
        else $error("second group code 3 misrouted");

    a_grp3_route: assert property (
        out_sel[`ROSL_GRP3_START] == 4'h3
            |=> o_pin_en[`ROSL_GRP3_START] && o_pin_out[`ROSL_GRP3_START] == $past(i_periph.reference_clock_out))
        else $error("third group code 3 misrouted");

    a_grp4_route: assert property (
        out_sel[`ROSL_GRP4_START] == 4'hc
            |=> o_pin_en[`ROSL_GRP4_START] && o_pin_out[`ROSL_GRP4_START] == $past(i_periph.compare_output_1))
        else $error("fourth group code c misrouted");

    a_locked_insel_kept: assert property (
        i_wr && in_hit && mapping_lock |=> $stable(o_in_sel))
        else $error("input selector changed while locked");

    a_sel_low_nibble: assert property (
        wr_out0 && !mapping_lock |=> out_sel[0] == $past(i_wdata[3:0]))
        else $error("selector write lost or widened");

    // the disable lets go at the release edge, so the next edge still sees reset values
    a_sel_reset_zero: assert property (
        $rose(i_rst_n) |-> out_sel[0] == 4'h0 && !o_pin_en[0] && !mapping_lock)
        else $error("selector not cleared by reset");

    a_option_capture: assert property (
        cfg_captured |-> one_way_lock_option == dcfg_word[`ROSL_ONEWAY_BIT])
        else $error("option and captured word disagree");

    a_soft_clear_option: assert property (
        $fell(mapping_lock) |-> !$past(one_way_lock_option))
        else $error("lock cleared under the one-way option");

    a_lock_port_match: assert property (
        o_mapping_lock == mapping_lock)
        else $error("lock output differs from lock");

    a_rdata_idle: assert property (
        !i_rd |=> o_rdata == 32'h0)
        else $error("read data outside its cycle");

    a_unmapped_read: assert property (
        i_rd && !(cfg_hit || key_hit || dcfg_hit || out_hit || in_hit) |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");

    a_insel_read: assert property (
        i_rd && in_hit && sel_idx == 6'h0 |=> o_rdata == {28'h0, $past(o_in_sel[0])})
        else $error("input selector read wrong");

    // ----------------------------------------
    // covers
    // ----------------------------------------
    c_lock_set:      cover property ($rose(mapping_lock));
    c_locked_write:  cover property (wr_out0 && mapping_lock);
    c_unlock_open:   cover property (key_state == KEY_HALF ##1 key_state == KEY_OPEN);
    c_pin_driven:    cover property ($rose(o_pin_en[0]));
    c_oneway_block:  cover property (lock_wr && !i_wdata[`ROSL_LOCK_BIT] && clr_block);

endmodule
`default_nettype wire

/* src/rosl_defines.svh */
`ifndef ROSL_DEFINES_SVH
`define ROSL_DEFINES_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define ROSL_ADDR_W      12
`define ROSL_CFG_ADDR    12'h000
`define ROSL_KEY_ADDR    12'h004
`define ROSL_DCFG_ADDR   12'h008
`define ROSL_OUT_REGION  4'h1
`define ROSL_IN_REGION   4'h2
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ROSL_LOCK_BIT    13
`define ROSL_ONEWAY_BIT  29
`define ROSL_SEL_RST     4'h0
`define ROSL_LOCK_RST    1'b0
// arbitrary unlock keys, first then second
`define ROSL_KEY_FIRST   32'haa99_6655
`define ROSL_KEY_SECOND  32'h5566_99aa
// ----------------------------------------
// pin groups (first index of each group)
// ----------------------------------------
`define ROSL_NUM_OUT     48
`define ROSL_GRP2_START  13
`define ROSL_GRP3_START  27
`define ROSL_GRP4_START  41
`endif

/* src/rosl_pkg.sv */
package rosl_pkg;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_HALF,
        KEY_OPEN
    } rosl_key_t;

    typedef struct packed {
        logic uart1_transmit;
        logic uart2_transmit;
        logic uart3_transmit;
        logic uart4_transmit;
        logic uart5_transmit;
        logic uart1_request_to_send;
        logic uart2_request_to_send;
        logic uart3_request_to_send;
        logic uart4_request_to_send;
        logic uart5_request_to_send;
        logic spi1_data_out;
        logic spi2_data_out;
        logic spi3_data_out;
        logic spi4_data_out;
        logic spi1_select;
        logic spi2_select;
        logic spi3_select;
        logic spi4_select;
        logic compare_output_1;
        logic compare_output_2;
        logic compare_output_3;
        logic compare_output_4;
        logic compare_output_5;
        logic can1_transmit;
        logic comparator1_output;
        logic comparator2_output;
        logic reference_clock_out;
    } rosl_periph_t;
endpackage

/* testbench/rosl_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// on-chip peripheral outputs
// ----------------------------------------
module rosl_periph_model
    import rosl_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    output var rosl_periph_t o_periph
);
    // rotate and invert: every bit moves each cycle, so a swapped route shows up
    wire rosl_periph_t next_periph = ~{o_periph[25:0], o_periph[26]};

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_periph <= 27'h2d3a5c1;
        end else begin
            o_periph <= next_periph;
        end
    end
endmodule
`default_nettype wire

/* testbench/rosl_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rosl_defines.svh"
module rosl_top_tb
    import rosl_pkg::*;
;
    localparam int IN_SELS = 34;
    // routed bits
    // struct bit picked by each code per group, ff drives nothing
    localparam logic [7:0] MAP [4][16] = '{
        '{8'hff, 8'h18, 8'h12, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h06, 8'h03, 8'h01, 8'h0e, 8'h0d},
        '{8'hff, 8'h19, 8'hff, 8'h1a, 8'h11, 8'hff, 8'hff, 8'hff, 8'h10, 8'hff, 8'hff, 8'h05, 8'hff, 8'hff, 8'h0e, 8'h0d},
        '{8'hff, 8'h13, 8'h17, 8'h00, 8'h16, 8'hff, 8'hff, 8'h0c, 8'h10, 8'hff, 8'hff, 8'h04, 8'hff, 8'h02, 8'h0a, 8'h09},
        '{8'hff, 8'h14, 8'hff, 8'h15, 8'h16, 8'hff, 8'h0b, 8'hff, 8'h10, 8'hff, 8'hff, 8'h07, 8'h08, 8'hff, 8'hff, 8'hff}
    };
    logic                     sys_clk, rst_n, wr, rd, lock, rd_d;
    logic [`ROSL_ADDR_W-1:0]  addr;
    logic [31:0]              wdata, cfg_word, rdata;
    rosl_periph_t             periph, p_q;
    logic [`ROSL_NUM_OUT-1:0] pin_out, pin_en;
    logic [IN_SELS-1:0][3:0]  in_sel;
    logic [7:0]               seed;
    logic [3:0]               in0;
    logic [31:0]              exp_q[$];
    int                       n_errors, n_tests;
    int                       grp_pin [4] = '{0, `ROSL_GRP2_START, `ROSL_GRP3_START, `ROSL_GRP4_START};

    rosl_top #(.IN_SELS(IN_SELS), .HAS_CAN(1'b1)) DUT (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .i_device_config_word_three(cfg_word), .i_periph(periph), .o_rdata(rdata), .o_pin_out(pin_out),
        .o_pin_en(pin_en), .o_in_sel(in_sel), .o_mapping_lock(lock));
    rosl_periph_model partner (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .o_periph(periph));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // bus tasks and compares
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic close_out;
        if (exp_q.size() != 0) begin
            n_errors++;
        end
        $display("counts: %0d compares, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge sys_clk);
        rd <= 1'b0;
    endtask

    task automatic unlock;
        wr_reg(`ROSL_KEY_ADDR, `ROSL_KEY_FIRST);
        wr_reg(`ROSL_KEY_ADDR, `ROSL_KEY_SECOND);
    endtask

    // pins follow selector and peripheral one cycle late
    task automatic chk_pin(input int pin, input int g, input logic [3:0] code);
        logic [7:0] m;
        m = MAP[g][code];
        @(posedge sys_clk);
        @(negedge sys_clk);
        cmp1(pin_en[pin], m != 8'hff);
        cmp1(pin_out[pin], (m != 8'hff) ? p_q[m[4:0]] : 1'b0);
    endtask

    task automatic do_reset(input logic [31:0] c);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        cfg_word <= c;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        p_q <= periph;
        rd_d <= rd;
    end
    always @(negedge sys_clk) begin
        if (rd_d === 1'b1) begin
            if (exp_q.size() != 0) begin
                cmp32(rdata, exp_q.pop_front());
            end else begin
                n_errors++;
                $display("mismatch at %0t: got %h expected %h", $time, rdata, ~rdata);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        $display("run limit reached");
        close_out;
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        cfg_word = 32'hffff_ffff;
        seed = 8'h57;
        in0 = 4'h0;
        do_reset(32'hffff_ffff);
        rd_reg(`ROSL_DCFG_ADDR, 32'hffff_ffff);
        rd_reg(`ROSL_CFG_ADDR, 32'h0000_0000);
        for (int i = 0; i < `ROSL_NUM_OUT; i++) begin
            rd_reg(12'h100 + 12'(4 * i), 32'h0000_0000);
        end
        cmp1(|pin_en, 1'b0);
        $display("test reset state done");
        for (int g = 0; g < 4; g++) begin
            for (int c = 0; c < 16; c++) begin
                seed = lfsr(seed);
                wr_reg(12'h100 + 12'(4 * grp_pin[g]), {seed, 20'h0, 4'(c)});
                rd_reg(12'h100 + 12'(4 * grp_pin[g]), {28'h0, 4'(c)});
                chk_pin(grp_pin[g], g, 4'(c));
            end
        end
        $display("test output codes done");
        for (int j = 0; j < IN_SELS; j++) begin
            seed = lfsr(seed);
            if (j == 0) begin
                in0 = seed[3:0];
            end
            wr_reg(12'h200 + 12'(4 * j), {28'h0, seed[3:0]});
            rd_reg(12'h200 + 12'(4 * j), {28'h0, seed[3:0]});
            cmp32({28'h0, in_sel[j]}, {28'h0, seed[3:0]});
        end
        rd_reg(12'h00c, 32'h0000_0000);
        rd_reg(12'h1c0, 32'h0000_0000);
        $display("test input selectors done");
        wr_reg(`ROSL_CFG_ADDR, 32'h0000_2000);
        @(negedge sys_clk);
        cmp1(lock, 1'b0);
        unlock;
        rd_reg(`ROSL_KEY_ADDR, 32'h0000_0002);
        wr_reg(`ROSL_CFG_ADDR, 32'h0000_2000);
        @(negedge sys_clk);
        cmp1(lock, 1'b1);
        rd_reg(`ROSL_CFG_ADDR, 32'h0000_2000);
        wr_reg(12'h100, 32'h0000_0001);
        wr_reg(12'h200, {28'h0, ~in0});
        rd_reg(12'h100, 32'h0000_000f);
        rd_reg(12'h200, {28'h0, in0});
        cmp32({28'h0, in_sel[0]}, {28'h0, in0});
        chk_pin(0, 0, 4'hf);
        rd_reg(`ROSL_DCFG_ADDR, 32'hffff_ffff);
        unlock;
        wr_reg(`ROSL_CFG_ADDR, 32'h0000_0000);
        @(negedge sys_clk);
        cmp1(lock, 1'b1);
        $display("test lock done");
        do_reset(32'hdfff_ffff);
        @(negedge sys_clk);
        cmp1(lock, 1'b0);
        rd_reg(12'h100, 32'h0000_0000);
        unlock;
        wr_reg(`ROSL_CFG_ADDR, 32'h0000_2000);
        unlock;
        wr_reg(`ROSL_CFG_ADDR, 32'h0000_0000);
        @(negedge sys_clk);
        cmp1(lock, 1'b0);
        wr_reg(12'h100, 32'h0000_0001);
        rd_reg(12'h100, 32'h0000_0001);
        chk_pin(0, 0, 4'h1);
        $display("test reset reopen done");
        repeat (2) @(posedge sys_clk);
        close_out;
    end
endmodule
`default_nettype wire
